//--- logic/wtx_reg_bank.sv
`timescale 1ns/1ps
// Contract
// - Answer on the two-wire bus at device address 0x61.
// - State byte reports charge sequence position; resets to zero.
// - Status byte reports fault condition code; resets to zero.
// - Coil current in mA, 16-bit read-only, low byte at lower address.
// - Coil voltage in mV, 16-bit read-only, low byte first.
// - Thermistor ADC code, 16-bit read-only, low byte first.
// - Bridge period count, 16-bit read-only, low byte first.
// - Bridge duty count, 16-bit read-only, low byte first.
// - Topology byte: zero half bridge, one full bridge.
// - Command bits 6:3 pick payload length 2 to 10 bytes; reset 0000.
// - Device clears the trigger bit once the data has been sent.
// - Received-data flag sets on new incoming data; resets to zero.
// - Writing one to interrupt-clear bit releases interrupt; bit self-clears.
// - Incoming header codes byte count: 18..78 hex, 84 hex for eight or more.
// - Eight received payload bytes readable from 0x0810.
module wtx_reg_bank (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic int_n,
  input wire logic [7:0] seq_state,
  input wire logic [7:0] fault_code,
  input wire logic [15:0] winding_amps,
  input wire logic [15:0] winding_volts,
  input wire logic [15:0] remote_temp_code,
  input wire logic [15:0] bridge_period_count,
  input wire logic [15:0] bridge_duty_count,
  input wire logic full_bridge,
  input wire logic link_tx_ready,
  output logic link_tx_valid,
  output logic [7:0] link_tx_data,
  output logic link_tx_last,
  input wire logic link_rx_valid,
  input wire logic [7:0] link_rx_data,
  input wire logic link_rx_last
);
  import wtx_pkg::*;

  logic [15:0] ptr;
  logic [1:0] wr_idx;
  logic [7:0] state_q, fault_q, topo_q;
  logic [15:0] amps_q, volts_q, temp_q, period_q, duty_q;
  logic [6:0] cmd_q;
  logic rx_flag, int_clear_bit;
  logic [7:0] rx_header;
  logic [3:0] rx_cnt;
  logic [7:0] tx_buf [TX_BYTES];
  logic [7:0] rx_buf [RX_BYTES];
  logic [TX_BYTES*8-1:0] tx_flat;
  logic [7:0] rd_byte;
  logic bus_start, wr_stb, rd_adv, send_done;
  logic [7:0] wr_data;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  wtx_i2c_slave u_slave (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .dev_addr(I2C_DEV_ADDR),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .bus_start(bus_start),
    .wr_stb(wr_stb),
    .wr_data(wr_data),
    .rd_data(rd_byte),
    .rd_adv(rd_adv)
  );

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  wire reg_wr = wr_stb & (wr_idx == 2'd2);
  wire wr_cmd = reg_wr & (ptr == ADDR_CMD);
  wire wr_rx_status = reg_wr & (ptr == ADDR_RX_STATUS);
  wire wr_int_clear = reg_wr & (ptr == ADDR_INT_CLEAR);
  wire trig = cmd_q[CMD_TRIG_BIT];
  wire send_start = wr_cmd & wr_data[CMD_TRIG_BIT] & ~trig;
  wire [3:0] next_len_code = wr_data[CMD_LEN_LSB +: 4];
  wire [1:0] next_rep_code = wr_data[CMD_REP_LSB +: 2];
  wire rx_done = link_rx_valid & link_rx_last;
  wire [3:0] rx_total = (rx_cnt < 4'(RX_BYTES)) ? rx_cnt + 4'h1 : rx_cnt;
  wire [7:0] next_rx_header = (rx_total == 4'(RX_BYTES)) ? RX_HDR_FULL
                              : {rx_total, RX_HDR_NIB};

  // ----------------------------------------
  // Address pointer
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ptr <= 16'h0000;
      wr_idx <= 2'd0;
    end else if (ce) begin
      if (bus_start) begin
        wr_idx <= 2'd0;
      end else if (wr_stb) begin
        if (wr_idx == 2'd0) begin
          ptr[15:8] <= wr_data;
          wr_idx <= 2'd1;
        end else if (wr_idx == 2'd1) begin
          ptr[7:0] <= wr_data;
          wr_idx <= 2'd2;
        end else begin
          ptr <= ptr + 16'h0001;
        end
      end else if (rd_adv) begin
        ptr <= ptr + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Telemetry capture
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= REG_RESET;
      fault_q <= REG_RESET;
      topo_q <= REG_RESET;
      amps_q <= 16'h0000;
      volts_q <= 16'h0000;
      temp_q <= 16'h0000;
      period_q <= 16'h0000;
      duty_q <= 16'h0000;
    end else if (ce) begin
      state_q <= seq_state;
      fault_q <= fault_code;
      topo_q <= {7'h00, full_bridge};
      amps_q <= winding_amps;
      volts_q <= winding_volts;
      temp_q <= remote_temp_code;
      period_q <= bridge_period_count;
      duty_q <= bridge_duty_count;
    end
  end

  // ----------------------------------------
  // Command register
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmd_q <= 7'h00;
    end else if (ce) begin
      if (wr_cmd) begin
        cmd_q <= wr_data[6:0] & CMD_WR_MASK[6:0];
      end else if (send_done) begin
        cmd_q[CMD_TRIG_BIT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Received-data flag, set wins over a write
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_flag <= 1'b0;
    end else if (ce) begin
      if (rx_done) begin
        rx_flag <= 1'b1;
      end else if (wr_rx_status) begin
        rx_flag <= wr_data[0];
      end
    end
  end

  // ----------------------------------------
  // Interrupt and its self-clearing bit
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      int_clear_bit <= 1'b0;
      int_n <= 1'b1;
    end else if (ce) begin
      int_clear_bit <= wr_int_clear & wr_data[0];
      if (rx_done) begin
        int_n <= 1'b0;
      end else if (int_clear_bit) begin
        int_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Payload buffers
  // ----------------------------------------
  generate
    for (genvar i = 0; i < TX_BYTES; i++) begin : g_tx
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          tx_buf[i] <= REG_RESET;
        end else if (ce && reg_wr && ptr == ADDR_TX_DATA + 16'(i)) begin
          tx_buf[i] <= wr_data;
        end
      end
      assign tx_flat[i*8 +: 8] = tx_buf[i];
    end
    for (genvar j = 0; j < RX_BYTES; j++) begin : g_rx
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          rx_buf[j] <= REG_RESET;
        end else if (ce && link_rx_valid && rx_cnt == 4'(j)) begin
          rx_buf[j] <= link_rx_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_cnt <= 4'h0;
      rx_header <= REG_RESET;
    end else if (ce && link_rx_valid) begin
      if (link_rx_last) begin
        rx_cnt <= 4'h0;
        rx_header <= next_rx_header;
      end else begin
        rx_cnt <= rx_total;
      end
    end
  end

  // ----------------------------------------
  // Outgoing sequencer
  // ----------------------------------------
  wtx_link_tx #(.NBYTES(TX_BYTES)) u_tx (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .start(send_start),
    .len_code(next_len_code),
    .rep_code(next_rep_code),
    .payload(tx_flat),
    .tx_ready(link_tx_ready),
    .tx_valid(link_tx_valid),
    .tx_data(link_tx_data),
    .tx_last(link_tx_last),
    .done(send_done)
  );

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire [15:0] tx_off = ptr - ADDR_TX_DATA;
  wire [15:0] rx_off = ptr - ADDR_RX_DATA;

  always_comb begin
    if (ptr == ADDR_STATE) begin
      rd_byte = state_q;
    end else if (ptr == ADDR_STATUS) begin
      rd_byte = fault_q;
    end else if (ptr == ADDR_AMPS_LO) begin
      rd_byte = amps_q[7:0];
    end else if (ptr == ADDR_AMPS_HI) begin
      rd_byte = amps_q[15:8];
    end else if (ptr == ADDR_VOLTS_LO) begin
      rd_byte = volts_q[7:0];
    end else if (ptr == ADDR_VOLTS_HI) begin
      rd_byte = volts_q[15:8];
    end else if (ptr == ADDR_TEMP_LO) begin
      rd_byte = temp_q[7:0];
    end else if (ptr == ADDR_TEMP_HI) begin
      rd_byte = temp_q[15:8];
    end else if (ptr == ADDR_PERIOD_LO) begin
      rd_byte = period_q[7:0];
    end else if (ptr == ADDR_PERIOD_HI) begin
      rd_byte = period_q[15:8];
    end else if (ptr == ADDR_DUTY_LO) begin
      rd_byte = duty_q[7:0];
    end else if (ptr == ADDR_DUTY_HI) begin
      rd_byte = duty_q[15:8];
    end else if (ptr == ADDR_TOPOLOGY) begin
      rd_byte = topo_q;
    end else if (ptr == ADDR_CMD) begin
      rd_byte = {1'b0, cmd_q};
    end else if (ptr == ADDR_RX_STATUS) begin
      rd_byte = {7'h00, rx_flag};
    end else if (ptr == ADDR_INT_CLEAR) begin
      rd_byte = {7'h00, int_clear_bit};
    end else if (tx_off < 16'(TX_BYTES)) begin
      rd_byte = tx_buf[tx_off[3:0]];
    end else if (ptr == ADDR_RX_HEADER) begin
      rd_byte = rx_header;
    end else if (rx_off < 16'(RX_BYTES)) begin
      rd_byte = rx_buf[rx_off[2:0]];
    end else begin
      rd_byte = UNMAPPED_READ;
    end
  end
endmodule

//--- logic/wtx_pkg.sv
package wtx_pkg;
  // ----------------------------------------
  // Bus address and widths
  // ----------------------------------------
  localparam logic [6:0] I2C_DEV_ADDR = 7'h61;
  localparam int ADDR_W = 16;
  localparam int TX_BYTES = 10;
  localparam int RX_BYTES = 8;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [15:0] ADDR_STATE = 16'h06E0;
  localparam logic [15:0] ADDR_STATUS = 16'h06E1;
  localparam logic [15:0] ADDR_AMPS_LO = 16'h06E2;
  localparam logic [15:0] ADDR_AMPS_HI = 16'h06E3;
  localparam logic [15:0] ADDR_VOLTS_LO = 16'h06E4;
  localparam logic [15:0] ADDR_VOLTS_HI = 16'h06E5;
  localparam logic [15:0] ADDR_TEMP_LO = 16'h06E8;
  localparam logic [15:0] ADDR_TEMP_HI = 16'h06E9;
  localparam logic [15:0] ADDR_PERIOD_LO = 16'h06EA;
  localparam logic [15:0] ADDR_PERIOD_HI = 16'h06EB;
  localparam logic [15:0] ADDR_DUTY_LO = 16'h06EC;
  localparam logic [15:0] ADDR_DUTY_HI = 16'h06ED;
  localparam logic [15:0] ADDR_TOPOLOGY = 16'h06EE;
  localparam logic [15:0] ADDR_CMD = 16'h0800;
  localparam logic [15:0] ADDR_RX_STATUS = 16'h0801;
  localparam logic [15:0] ADDR_INT_CLEAR = 16'h0803;
  localparam logic [15:0] ADDR_TX_DATA = 16'h0805;
  localparam logic [15:0] ADDR_RX_HEADER = 16'h080F;
  localparam logic [15:0] ADDR_RX_DATA = 16'h0810;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CMD_TRIG_BIT = 0;
  localparam int CMD_REP_LSB = 1;
  localparam int CMD_LEN_LSB = 3;
  localparam logic [7:0] CMD_WR_MASK = 8'h7F;
  localparam logic [3:0] LEN_CODE_MAX = 4'h4;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] RX_HDR_FULL = 8'h84;
  localparam logic [3:0] RX_HDR_NIB = 4'h8;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------
  // Charge sequence and fault codes
  // ----------------------------------------
  localparam logic [7:0] ST_STARTUP = 8'h00;
  localparam logic [7:0] ST_IDLE = 8'h01;
  localparam logic [7:0] ST_ANALOG_PING = 8'h02;
  localparam logic [7:0] ST_DIGITAL_PING = 8'h04;
  localparam logic [7:0] ST_IDENT = 8'h05;
  localparam logic [7:0] ST_CONFIG = 8'h07;
  localparam logic [7:0] ST_PT_INIT = 8'h08;
  localparam logic [7:0] ST_PT = 8'h09;
  localparam logic [7:0] ST_REMOVE = 8'h0B;
  localparam logic [7:0] ST_RESTART = 8'h0C;
  localparam logic [7:0] ST_NEGOTIATE = 8'h0D;
  localparam logic [7:0] FC_NORMAL = 8'h00;
  localparam logic [7:0] FC_STRAY_METAL_ALARM = 8'h01;
  localparam logic [7:0] FC_STOP_COMPLETE = 8'h02;
  localparam logic [7:0] FC_STOP_NO_RESPONSE = 8'h04;
  localparam logic [7:0] FC_STOP_INTERNAL = 8'h05;
  localparam logic [7:0] FC_OVER_TEMP = 8'h06;
  localparam logic [7:0] FC_OVER_CURRENT = 8'h07;
  localparam logic [7:0] FC_STOP_RX_FAULT = 8'h09;
  localparam logic [7:0] FC_NEGOTIATE_FAIL = 8'h0A;
endpackage

//--- logic/wtx_i2c_slave.sv
`timescale 1ns/1ps
module wtx_i2c_slave (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [6:0] dev_addr,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic bus_start,
  output logic wr_stb,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  output logic rd_adv
);
  import wtx_pkg::*;

  typedef enum logic [2:0] {
    WI_IDLE, WI_DEV, WI_DEV_ACK, WI_WR, WI_WR_ACK, WI_RD, WI_RD_ACK
  } wi_state_e;

  wi_state_e state;
  logic scl_q, sda_q;
  logic [7:0] rx_sh, tx_sh;
  logic [3:0] cnt;
  logic is_read, master_ack;

  // ----------------------------------------
  // Line events
  // ----------------------------------------
  wire scl_rise = scl_i & ~scl_q;
  wire scl_fall = ~scl_i & scl_q;
  wire start_ev = scl_i & scl_q & sda_q & ~sda_i;
  wire stop_ev = scl_i & scl_q & ~sda_q & sda_i;
  wire addr_hit = (rx_sh[7:1] == dev_addr);

  assign sda_o = 1'b0;
  assign sda_oe = (state == WI_DEV_ACK) | (state == WI_WR_ACK) | ((state == WI_RD) & ~tx_sh[7]);

  // ----------------------------------------
  // Byte engine
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= WI_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rx_sh <= REG_RESET;
      tx_sh <= 8'hFF;
      cnt <= 4'h0;
      is_read <= 1'b0;
      master_ack <= 1'b0;
      bus_start <= 1'b0;
      wr_stb <= 1'b0;
      wr_data <= REG_RESET;
      rd_adv <= 1'b0;
    end else if (ce) begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      bus_start <= 1'b0;
      wr_stb <= 1'b0;
      rd_adv <= 1'b0;
      if (start_ev) begin
        state <= WI_DEV;
        cnt <= 4'h0;
        bus_start <= 1'b1;
      end else if (stop_ev) begin
        state <= WI_IDLE;
      end else if (scl_rise) begin
        if (state == WI_DEV || state == WI_WR) begin
          rx_sh <= {rx_sh[6:0], sda_i};
          cnt <= cnt + 4'h1;
        end else if (state == WI_RD_ACK) begin
          master_ack <= ~sda_i;
        end
      end else if (scl_fall) begin
        case (state)
          WI_DEV: begin
            if (cnt == 4'h8) begin
              is_read <= rx_sh[0];
              state <= addr_hit ? WI_DEV_ACK : WI_IDLE;
            end
          end
          WI_DEV_ACK: begin
            cnt <= 4'h0;
            if (is_read) begin
              tx_sh <= rd_data;
              rd_adv <= 1'b1;
              state <= WI_RD;
            end else begin
              state <= WI_WR;
            end
          end
          WI_WR: begin
            if (cnt == 4'h8) begin
              wr_stb <= 1'b1;
              wr_data <= rx_sh;
              state <= WI_WR_ACK;
            end
          end
          WI_WR_ACK: begin
            cnt <= 4'h0;
            state <= WI_WR;
          end
          WI_RD: begin
            if (cnt == 4'h7) begin
              tx_sh <= 8'hFF;
              state <= WI_RD_ACK;
            end else begin
              tx_sh <= {tx_sh[6:0], 1'b1};
              cnt <= cnt + 4'h1;
            end
          end
          WI_RD_ACK: begin
            cnt <= 4'h0;
            if (master_ack) begin
              tx_sh <= rd_data;
              rd_adv <= 1'b1;
              state <= WI_RD;
            end else begin
              state <= WI_IDLE;
            end
          end
          default: state <= WI_IDLE;
        endcase
      end
    end
  end
endmodule

//--- logic/wtx_link_tx.sv
`timescale 1ns/1ps
module wtx_link_tx #(
  parameter int NBYTES = 10
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic [3:0] len_code,
  input wire logic [1:0] rep_code,
  input wire logic [NBYTES*8-1:0] payload,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic done
);
  import wtx_pkg::*;

  typedef enum logic {WT_IDLE, WT_SEND} wt_state_e;

  wt_state_e state;
  logic [3:0] idx, last_idx;
  logic [1:0] reps_left;

  // ----------------------------------------
  // Length decode
  // ----------------------------------------
  wire [3:0] len_clamp = (len_code > LEN_CODE_MAX) ? LEN_CODE_MAX : len_code;
  wire [3:0] next_last_idx = {len_clamp[2:0], 1'b1};

  assign tx_valid = (state == WT_SEND);
  assign tx_data = payload[idx*8 +: 8];
  assign tx_last = tx_valid & (idx == last_idx);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= WT_IDLE;
      idx <= 4'h0;
      last_idx <= 4'h1;
      reps_left <= 2'b00;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      case (state)
        WT_IDLE: begin
          if (start) begin
            idx <= 4'h0;
            last_idx <= next_last_idx;
            reps_left <= rep_code;
            state <= WT_SEND;
          end
        end
        WT_SEND: begin
          if (tx_ready) begin
            if (idx == last_idx) begin
              idx <= 4'h0;
              if (reps_left == 2'b00) begin
                done <= 1'b1;
                state <= WT_IDLE;
              end else begin
                reps_left <= reps_left - 2'b01;
              end
            end else begin
              idx <= idx + 4'h1;
            end
          end
        end
        default: state <= WT_IDLE;
      endcase
    end
  end
endmodule

//--- verif/wtx_reg_bank_checker.sv
`timescale 1ns/1ps
module wtx_reg_bank_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic int_n,
  input wire logic link_tx_ready,
  input wire logic link_tx_valid,
  input wire logic [7:0] link_tx_data,
  input wire logic link_tx_last,
  input wire logic link_rx_valid,
  input wire logic link_rx_last
);
  // ----------------------------------------
  // Bytes accepted since the last repeat end
  // ----------------------------------------
  logic [3:0] acc_cnt;
  logic acc;
  assign acc = ce && link_tx_valid && link_tx_ready;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_cnt <= 4'h0;
    end else if (acc) begin
      acc_cnt <= link_tx_last ? 4'h0 : acc_cnt + 4'h1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  open_drain_a: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  ack_edge_a: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data enable moved while clock high");
  ack_hold_a: assert property ($rose(scl_i) && sda_oe |=> sda_oe [*3])
    else $error("data enable dropped in high phase");
  tx_stand_a: assert property (link_tx_valid && !link_tx_ready |=>
    link_tx_valid && $stable(link_tx_data) && $stable(link_tx_last))
    else $error("stalled byte changed");
  last_valid_a: assert property (link_tx_last |-> link_tx_valid)
    else $error("last marker without valid");
  tx_len_a: assert property (acc && link_tx_last |->
    acc_cnt inside {4'h1, 4'h3, 4'h5, 4'h7, 4'h9})
    else $error("odd payload length");
  tx_end_a: assert property ($fell(link_tx_valid) |->
    $past(link_tx_ready) && $past(link_tx_last))
    else $error("send stopped before last byte");
  rx_int_a: assert property (ce && link_rx_valid && link_rx_last |=> !int_n)
    else $error("no interrupt after frame");
  int_cause_a: assert property ($fell(int_n) |->
    $past(link_rx_valid) && $past(link_rx_last))
    else $error("interrupt without frame end");
endmodule
bind wtx_reg_bank wtx_reg_bank_checker u_wtx_reg_bank_checker (
  .sys_clk(sys_clk), .rst(rst), .ce(ce), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .int_n(int_n), .link_tx_ready(link_tx_ready),
  .link_tx_valid(link_tx_valid), .link_tx_data(link_tx_data),
  .link_tx_last(link_tx_last), .link_rx_valid(link_rx_valid),
  .link_rx_last(link_rx_last)
);

//--- verif/wtx_host_model.sv
`timescale 1ns/1ps
module wtx_host_model (
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  import wtx_pkg::*;
  // ----------------------------------------
  // Two-wire bus master, line changes on clock edges
  // ----------------------------------------
  localparam int HALF = 5;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt();
    repeat (HALF) @(posedge sys_clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    @(posedge sys_clk);
    sda_low <= !b;
    wt();
    scl <= 1'b1;
    wt();
    r = sda_line;
    scl <= 1'b0;
  endtask
  task automatic start();
    @(posedge sys_clk);
    sda_low <= 1'b0;
    wt();
    scl <= 1'b1;
    wt();
    sda_low <= 1'b1;
    wt();
    scl <= 1'b0;
  endtask
  task automatic stop();
    @(posedge sys_clk);
    sda_low <= 1'b1;
    wt();
    scl <= 1'b1;
    wt();
    sda_low <= 1'b0;
    wt();
  endtask
  task automatic tx8(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rx8(input logic nack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(nack, r);
  endtask
  task automatic wr(input logic [6:0] dev, input logic [15:0] a, input logic [7:0] d,
                    output logic ack);
    logic k;
    start();
    tx8({dev, 1'b0}, ack);
    tx8(a[15:8], k);
    tx8(a[7:0], k);
    tx8(d, k);
    stop();
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    logic k;
    start();
    tx8({I2C_DEV_ADDR, 1'b0}, k);
    tx8(a[15:8], k);
    tx8(a[7:0], k);
    start();
    tx8({I2C_DEV_ADDR, 1'b1}, k);
    rx8(1'b0, v[7:0]);
    rx8(1'b1, v[15:8]);
    stop();
  endtask
endmodule

//--- verif/test_wtx_reg_bank.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end
module test_wtx_reg_bank;
  import wtx_pkg::*;
  // ----------------------------------------
  // Signals and tables
  // ----------------------------------------
  int fails = 0;
  int n_tests = 0;
  int n;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic scl, host_low, sda_line, sda_o, sda_oe, int_n, ack, busy, tx_valid, tx_last;
  logic full_bridge = 1'b0;
  logic tx_ready = 1'b0;
  logic rx_valid = 1'b0;
  logic rx_last = 1'b0;
  logic [7:0] seq_state = 8'h00;
  logic [7:0] fault_code = 8'h00;
  logic [7:0] rx_data = 8'h00;
  logic [7:0] tx_data, hdr;
  logic [1:0] stall = 2'h0;
  logic [3:0] len;
  logic [8:0] e;
  logic [8:0] exp_q [$];
  logic [15:0] v;
  logic [15:0] tele [5] = '{16'h8001, 16'h4302, 16'h0FFF, 16'h01C8, 16'h00FE};
  logic [15:0] tele_addr [5] = '{ADDR_AMPS_LO, ADDR_VOLTS_LO, ADDR_TEMP_LO,
    ADDR_PERIOD_LO, ADDR_DUTY_LO};
  logic [7:0] st_tab [11] = '{ST_STARTUP, ST_IDLE, ST_ANALOG_PING, ST_DIGITAL_PING,
    ST_IDENT, ST_CONFIG, ST_PT_INIT, ST_PT, ST_REMOVE, ST_RESTART, ST_NEGOTIATE};
  logic [7:0] fc_tab [9] = '{FC_NORMAL, FC_STRAY_METAL_ALARM, FC_STOP_COMPLETE,
    FC_STOP_NO_RESPONSE, FC_STOP_INTERNAL, FC_OVER_TEMP, FC_OVER_CURRENT,
    FC_STOP_RX_FAULT, FC_NEGOTIATE_FAIL};
  logic [7:0] cmd_tab [6] = '{8'h07, 8'h09, 8'h13, 8'h1D, 8'h23, 8'hFF};
  int nrx_tab [3] = '{1, 7, 9};
  assign sda_line = (host_low || sda_oe) ? 1'b0 : 1'b1;
  always #4 sys_clk = ~sys_clk;
  wtx_reg_bank u_wtx_reg_bank (
    .sys_clk(sys_clk), .rst(rst), .ce(1'b1), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .int_n(int_n), .seq_state(seq_state),
    .fault_code(fault_code), .winding_amps(tele[0]), .winding_volts(tele[1]),
    .remote_temp_code(tele[2]), .bridge_period_count(tele[3]),
    .bridge_duty_count(tele[4]), .full_bridge(full_bridge), .link_tx_ready(tx_ready),
    .link_tx_valid(tx_valid), .link_tx_data(tx_data), .link_tx_last(tx_last),
    .link_rx_valid(rx_valid), .link_rx_data(rx_data), .link_rx_last(rx_last)
  );
  wtx_host_model u_wtx_host_model (
    .sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_low(host_low)
  );
  // ----------------------------------------
  // Link sink with stalls and byte check
  // ----------------------------------------
  always @(posedge sys_clk) begin
    stall <= stall + 2'h1;
    tx_ready <= (stall != 2'h1);
    if (!rst && tx_valid && tx_ready) begin
      if (exp_q.size() == 0) begin
        `CHK(1'b0, 1'b1)
      end else begin
        e = exp_q.pop_front();
        `CHK({tx_last, tx_data}, e)
      end
    end
  end
  task automatic summarize();
    $display("comparisons=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] r;
    u_wtx_host_model.rd(a, r);
    `CHK(r, exp)
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic k;
    u_wtx_host_model.wr(I2C_DEV_ADDR, a, d, k);
    `CHK(k, 1'b1)
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rchk(ADDR_CMD, 16'h0000);
    rchk(ADDR_TX_DATA, 16'h0000);
    u_wtx_host_model.wr(7'h62, ADDR_CMD, 8'h01, ack);
    `CHK(ack, 1'b0)
    for (int i = 0; i < 11; i++) begin
      seq_state <= st_tab[i];
      fault_code <= fc_tab[i % 9];
      rchk(ADDR_STATE, {fc_tab[i % 9], st_tab[i]});
    end
    wr(ADDR_STATE, 8'hFF);
    rchk(ADDR_STATE, {fc_tab[1], st_tab[10]});
    rchk(16'h0700, 16'h0000);
    for (int i = 0; i < 5; i++) rchk(tele_addr[i], tele[i]);
    for (int i = 0; i < 2; i++) begin
      full_bridge <= i[0];
      rchk(ADDR_TOPOLOGY, {15'h0000, i[0]});
    end
    for (int i = 0; i < 10; i++) wr(ADDR_TX_DATA + 16'(i), 8'hC0 + 8'(i));
    for (int c = 0; c < 6; c++) begin
      len = (cmd_tab[c][6:3] > LEN_CODE_MAX) ? LEN_CODE_MAX : cmd_tab[c][6:3];
      for (int r = 0; r <= int'(cmd_tab[c][2:1]); r++) begin
        for (int i = 0; i < (len + 1) * 2; i++) begin
          exp_q.push_back({i == (len + 1) * 2 - 1, 8'hC0 + 8'(i)});
        end
      end
      wr(ADDR_CMD, cmd_tab[c]);
      busy = 1'b1;
      for (int k = 0; k < 20 && busy; k++) begin
        u_wtx_host_model.rd(ADDR_CMD, v);
        busy = v[0];
      end
      `CHK(v, {8'h00, cmd_tab[c] & 8'h7E})
      `CHK(exp_q.size(), 0)
      if (busy) begin
        summarize();
      end
    end
    for (int f = 0; f < 3; f++) begin
      n = nrx_tab[f];
      for (int k = 0; k < n; k++) begin
        @(posedge sys_clk);
        rx_valid <= 1'b1;
        rx_data <= {4'(n), 4'(k)};
        rx_last <= (k == n - 1);
      end
      @(posedge sys_clk);
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      repeat (2) @(posedge sys_clk);
      `CHK(int_n, 1'b0)
      hdr = (n < 8) ? {4'(n), RX_HDR_NIB} : RX_HDR_FULL;
      rchk(ADDR_RX_STATUS, 16'h0001);
      rchk(ADDR_RX_HEADER, {4'(n), 4'h0, hdr});
      if (n > 7) rchk(ADDR_RX_DATA + 16'h6, {4'(n), 4'h7, 4'(n), 4'h6});
      wr(ADDR_INT_CLEAR, 8'h01);
      repeat (3) @(posedge sys_clk);
      `CHK(int_n, 1'b1)
      rchk(ADDR_INT_CLEAR, 16'h0000);
      wr(ADDR_RX_STATUS, 8'hFE);
      rchk(ADDR_RX_STATUS, 16'h0000);
    end
    summarize();
  end
endmodule
